// ### rtl/otm_defs.vh
/*
 * Constants for the one-shot / PWM timer channel: register offsets,
 * field positions, mode and select codes, reset values and PWM periods.
 * Assumes inclusion by the prescaler and timer design files of the channel.
 */
`ifndef OTM_DEFS_VH
`define OTM_DEFS_VH

// Register byte offsets
`define OTM_OFS_CTRL 5'h00
`define OTM_OFS_MODE 5'h04
`define OTM_OFS_COUNT 5'h08
`define OTM_OFS_ZCTRL 5'h0C
`define OTM_OFS_STATUS 5'h10

// Control register fields
`define OTM_CTRL_RUN 0
`define OTM_CTRL_SWTRIG 1

// Mode register fields
`define OTM_MODE_SEL_LO 0
`define OTM_MODE_SEL_HI 1
`define OTM_MODE_PWM8 2
`define OTM_MODE_POUT 3
`define OTM_MODE_CLK_LO 4
`define OTM_MODE_CLK_HI 6
`define OTM_MODE_TRIG_LO 7
`define OTM_MODE_TRIG_HI 8
`define OTM_MODE_PWMWAIT 9
`define OTM_MODE_TPOL 10
`define OTM_MODE_TWOPH 11
`define OTM_MODE_FREERUN 12
`define OTM_MODE_X4 13
`define OTM_MODE_W 14

// Z-phase control fields
`define OTM_Z_EN 0
`define OTM_Z_POL 1

// Operating modes
`define OTM_MD_ONESHOT 2'h0
`define OTM_MD_PWM 2'h1
`define OTM_MD_EVENT 2'h2

// Count source codes
`define OTM_CS_F1 3'h0
`define OTM_CS_F2 3'h1
`define OTM_CS_F8 3'h2
`define OTM_CS_F32 3'h3
`define OTM_CS_SUBCLOCK_DIV32 3'h4

// Trigger source codes
`define OTM_TS_PIN 2'h0
`define OTM_TS_PARTNER 2'h1
`define OTM_TS_LOWER 2'h2
`define OTM_TS_UPPER 2'h3

// Values
`define OTM_ZERO16 16'h0000
`define OTM_ONE16 16'h0001
`define OTM_UNDEF16 16'hFFFF
`define OTM_PWM16_LAST 16'hFFFE
`define OTM_PWM8_LAST 16'h00FE
`define OTM_NCHAN 3'h5
`define OTM_LAST_CHAN 3'h4
`define OTM_FIRST_CHAN 3'h0

`endif

// ### rtl/otm_edge_det.v
/*
 * Edge detector with selectable polarity: one-cycle pulse on the chosen
 * edge of a level. Assumes the level is synchronous to the clock.
 */
`timescale 1ns/1ps
`default_nettype none
module otm_edge_det
(
   // Clock and reset
   input wire i_ref_clk,
   input wire i_sys_rst,
   // Level and polarity, 1 = rising
   input wire i_level,
   input wire i_rise,
   // Edge pulse
   output wire o_edge
);
   reg prev_r;

   assign o_edge = i_rise ? (i_level & ~prev_r) : (~i_level & prev_r);

   always @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
         prev_r <= 1'b0;
      else
         prev_r <= i_level;
   end
endmodule
`default_nettype wire

// ### rtl/otm_prescaler.v
/*
 * Count source generator: one-cycle ticks at the system clock divided
 * by 1, 2, 8 or 32, or the sub-clock tick divided by 32.
 * Assumes i_subclk_tick is a synchronous one-cycle pulse per sub-clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "otm_defs.vh"
module otm_prescaler
(
   // Clock and reset
   input wire i_ref_clk,
   input wire i_sys_rst,
   // Selection and sub-clock
   input wire [2:0] i_sel,
   input wire i_subclk_tick,
   // Count source
   output reg o_tick
);
   reg [4:0] div_r;
   reg [4:0] sub_r;
   reg tick_nxt;

   always @*
   begin
      case (i_sel)
         `OTM_CS_F1: tick_nxt = 1'b1;
         `OTM_CS_F2: tick_nxt = div_r[0];
         `OTM_CS_F8: tick_nxt = &div_r[2:0];
         `OTM_CS_F32: tick_nxt = &div_r;
         `OTM_CS_SUBCLOCK_DIV32: tick_nxt = i_subclk_tick & (&sub_r);
         default: tick_nxt = 1'b0;
      endcase
   end

   always @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         div_r <= 5'h00;
         sub_r <= 5'h00;
         o_tick <= 1'b0;
      end
      else
      begin
         div_r <= div_r + 5'h01;
         if (i_subclk_tick)
            sub_r <= sub_r + 5'h01;
         o_tick <= tick_nxt;
      end
   end
endmodule
`default_nettype wire

// ### rtl/otm_timer.v
/*
 * One timer channel: one-shot timer, 16/8-bit PWM and Z-phase clearing
 * for the quadrature channel, with an Avalon-MM register slave.
 * Assumes synchronous inputs, a quadrature counter outside that takes
 * o_zclear and supplies its count, count timing and overflow pulses.
 */
// Notes on behaviour
// [RL1] Z-phase event clears quadrature count to zero
// [RL2] Z clear only on quadrature channel, x4 free-run
// [RL3] Software zeroes count, then enables Z clear
// [RL4] Z edge direction set by polarity bit
// [RL5] Z pulse lasts one count source period
// [RL6] Zero-clear applied at next count timing
// [RL7] Coinciding overflow and clear give two requests
// [RL8] Count source: f1, f2, f8, f32, sub/32
// [RL9] One-shot counts down, reloads at zero, stops
// [RL10] Trigger while running reloads and restarts
// [RL11] One-shot lasts n periods; zero never counts
// [RL12] One-shot starts on trigger while run set
// [RL13] Neighbours wrap around five channels
// [RL14] One-shot request when counter reaches zero
// [RL15] Count reads undefined in one-shot, PWM
// [RL16] Early writes load counter; later reload only
// [RL17] Pulse output low idle, high counting
// [RL18] PWM reloads at rising edge; ignores triggers
// [RL19] 16-bit PWM: high n, cycle 65535
// [RL20] 8-bit PWM: high n(m+1), cycle 255(m+1)
// [RL21] PWM starts on run or trigger; run clear stops
// [RL22] PWM request at falling output edge
`timescale 1ns/1ps
`default_nettype none
`include "otm_defs.vh"
module otm_timer
#(
   parameter [2:0] CHAN_IDX = 3'h3,
   parameter QUAD_CHAN = 1,
   parameter ADDR_W = 5
)
(
   // Clock and reset
   input wire i_ref_clk,
   input wire i_sys_rst,
   // Avalon-MM slave
   input wire [ADDR_W-1:0] i_avs_address,
   input wire i_avs_read,
   input wire i_avs_write,
   input wire [31:0] i_avs_writedata,
   output reg [31:0] o_avs_readdata,
   output reg o_avs_waitrequest,
   // Trigger sources and sub-clock tick
   input wire i_trigger_input_pin,
   input wire i_partner_ovf,
   input wire [4:0] i_chan_ovf,
   input wire i_subclk_tick,
   // Z-phase and quadrature counter
   input wire i_zphase_pin,
   input wire i_quad_count_tick,
   input wire i_quad_ovf,
   input wire [15:0] i_quad_count,
   output reg o_zclear,
   // Pulse output pin and request
   output reg o_pulse_output_pin,
   output reg o_pulse_output_oe,
   output reg o_irq_req
);
   reg run_r;
   reg [`OTM_MODE_W-1:0] mode_r;
   reg zen_r;
   reg zpol_r;
   reg [15:0] reload_r;
   reg [15:0] cnt_r;
   reg [15:0] duty_r;
   reg [7:0] pre_r;
   reg [7:0] m_r;
   reg counting_r;
   reg first_r;
   reg zpend_r;
   reg irq2_r;
   reg swtrig_r;
   reg out_nxt;
   reg [31:0] rdata_nxt;
   wire [1:0] md;
   wire pwm8;
   wire [1:0] tsel;
   wire tick;
   wire pin_edge;
   wire z_edge;
   wire acc;
   wire wr_go;
   wire [4:0] word_adr;
   wire trig_any;
   wire os_mode;
   wire pwm_mode;
   wire z_ok;
   wire early;
   wire pwm_step;
   wire [15:0] pwm_last;

   function [2:0] lower_nbr;
      input [2:0] idx;
      begin
         lower_nbr = (idx == `OTM_FIRST_CHAN) ? `OTM_LAST_CHAN : idx - 3'h1;
      end
   endfunction

   function [2:0] upper_nbr;
      input [2:0] idx;
      begin
         upper_nbr = (idx == `OTM_LAST_CHAN) ? `OTM_FIRST_CHAN : idx + 3'h1;
      end
   endfunction

   assign md = mode_r[`OTM_MODE_SEL_HI:`OTM_MODE_SEL_LO];
   assign pwm8 = mode_r[`OTM_MODE_PWM8];
   assign tsel = mode_r[`OTM_MODE_TRIG_HI:`OTM_MODE_TRIG_LO];
   assign os_mode = (md == `OTM_MD_ONESHOT);
   assign pwm_mode = (md == `OTM_MD_PWM);
   assign word_adr = {i_avs_address[4:2], 2'b00};
   assign acc = i_avs_read | i_avs_write;
   assign wr_go = i_avs_write & ~o_avs_waitrequest;

   // Count source selection
   otm_prescaler u_presc
   (
      .i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst),
      .i_sel(mode_r[`OTM_MODE_CLK_HI:`OTM_MODE_CLK_LO]), // RL8
      .i_subclk_tick(i_subclk_tick),
      .o_tick(tick)
   );

   otm_edge_det u_trig_edge
   (
      .i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst),
      .i_level(i_trigger_input_pin),
      .i_rise(mode_r[`OTM_MODE_TPOL]),
      .o_edge(pin_edge)
   );

   otm_edge_det u_z_edge
   (
      .i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst),
      .i_level(i_zphase_pin),
      .i_rise(zpol_r), // RL4
      .o_edge(z_edge) // RL5
   );

   // Hardware trigger selected from pin, partner or a neighbour
   assign trig_any = (tsel == `OTM_TS_PIN) ? pin_edge :
                     (tsel == `OTM_TS_PARTNER) ? i_partner_ovf :
                     (tsel == `OTM_TS_LOWER) ? i_chan_ovf[lower_nbr(CHAN_IDX)] : // RL13
                     i_chan_ovf[upper_nbr(CHAN_IDX)]; // RL13

   // Z clear allowed only on the quadrature channel in x4 free-run
   assign z_ok = (QUAD_CHAN != 0) && (md == `OTM_MD_EVENT) && zen_r &&
                 mode_r[`OTM_MODE_TWOPH] && mode_r[`OTM_MODE_FREERUN] &&
                 mode_r[`OTM_MODE_X4]; // RL2

   // Counter loads too while stopped or before the first count source
   assign early = ~counting_r | ~first_r;

   // PWM position advance, divided by m+1 in 8-bit mode
   assign pwm_step = tick & (~pwm8 | (pre_r == m_r));
   assign pwm_last = pwm8 ? `OTM_PWM8_LAST : `OTM_PWM16_LAST;

   // Pulse output level for the next cycle, PWM or one-shot
   always @*
   begin
      out_nxt = 1'b0;
      if (pwm_mode && counting_r && run_r)
         out_nxt = (cnt_r < duty_r); // RL19 RL20
      else if (os_mode)
         out_nxt = counting_r; // RL17
   end

   // Read data mux
   always @*
   begin
      rdata_nxt = 32'h00000000;
      case (word_adr)
         `OTM_OFS_CTRL: rdata_nxt[`OTM_CTRL_RUN] = run_r;
         `OTM_OFS_MODE: rdata_nxt[`OTM_MODE_W-1:0] = mode_r;
         `OTM_OFS_COUNT:
         begin
            if (md == `OTM_MD_EVENT)
               rdata_nxt[15:0] = i_quad_count;
            else
               rdata_nxt[15:0] = `OTM_UNDEF16; // RL15
         end
         `OTM_OFS_ZCTRL:
         begin
            rdata_nxt[`OTM_Z_EN] = zen_r;
            rdata_nxt[`OTM_Z_POL] = zpol_r;
         end
         `OTM_OFS_STATUS: rdata_nxt[3:0] = {zpend_r, first_r, o_pulse_output_pin, counting_r};
         default: rdata_nxt = 32'h00000000;
      endcase
   end

   // Avalon-MM slave: one wait state, write takes effect when released
   always @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         o_avs_waitrequest <= 1'b1;
         o_avs_readdata <= 32'h00000000;
      end
      else if (acc && o_avs_waitrequest)
      begin
         o_avs_waitrequest <= 1'b0;
         o_avs_readdata <= rdata_nxt;
      end
      else
         o_avs_waitrequest <= 1'b1;
   end

   // Configuration registers
   always @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         run_r <= 1'b0;
         mode_r <= {`OTM_MODE_W{1'b0}};
         zen_r <= 1'b0;
         zpol_r <= 1'b0;
         swtrig_r <= 1'b0;
      end
      else
      begin
         swtrig_r <= 1'b0;
         if (wr_go)
         begin
            case (word_adr)
               `OTM_OFS_CTRL:
               begin
                  run_r <= i_avs_writedata[`OTM_CTRL_RUN];
                  swtrig_r <= i_avs_writedata[`OTM_CTRL_SWTRIG];
               end
               `OTM_OFS_MODE: mode_r <= i_avs_writedata[`OTM_MODE_W-1:0];
               `OTM_OFS_ZCTRL:
               begin
                  zen_r <= i_avs_writedata[`OTM_Z_EN]; // RL3
                  zpol_r <= i_avs_writedata[`OTM_Z_POL];
               end
               default: run_r <= run_r;
            endcase
         end
      end
   end

   // Reload register
   always @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
         reload_r <= `OTM_ZERO16;
      else if (wr_go && word_adr == `OTM_OFS_COUNT)
         reload_r <= i_avs_writedata[15:0]; // RL16
   end

   // Counter, PWM divider and run state
   always @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         cnt_r <= `OTM_ZERO16;
         duty_r <= `OTM_ZERO16;
         pre_r <= 8'h00;
         m_r <= 8'h00;
         counting_r <= 1'b0;
         first_r <= 1'b0;
      end
      else if (!run_r)
      begin
         counting_r <= 1'b0; // RL9 RL21
         first_r <= 1'b0;
         if (wr_go && word_adr == `OTM_OFS_COUNT)
            cnt_r <= i_avs_writedata[15:0]; // RL16
      end
      else if (os_mode)
      begin
         if (swtrig_r || trig_any) // RL12
         begin
            cnt_r <= reload_r; // RL10
            counting_r <= (reload_r != `OTM_ZERO16); // RL11
            first_r <= 1'b0;
         end
         else if (counting_r && tick)
         begin
            first_r <= 1'b1;
            if (cnt_r == `OTM_ONE16)
            begin
               cnt_r <= reload_r; // RL9
               counting_r <= 1'b0;
            end
            else
               cnt_r <= cnt_r - `OTM_ONE16;
         end
         else if (wr_go && word_adr == `OTM_OFS_COUNT && early)
            cnt_r <= i_avs_writedata[15:0]; // RL16
      end
      else if (pwm_mode)
      begin
         if (!counting_r)
         begin
            if (!mode_r[`OTM_MODE_PWMWAIT] || trig_any) // RL21
            begin
               counting_r <= 1'b1;
               first_r <= 1'b0;
               cnt_r <= `OTM_ZERO16;
               pre_r <= 8'h00;
               duty_r <= pwm8 ? {8'h00, reload_r[15:8]} : reload_r;
               m_r <= pwm8 ? reload_r[7:0] : 8'h00;
            end
         end
         else
         begin
            if (wr_go && word_adr == `OTM_OFS_COUNT && early)
            begin
               duty_r <= pwm8 ? {8'h00, i_avs_writedata[15:8]} : i_avs_writedata[15:0];
               m_r <= pwm8 ? i_avs_writedata[7:0] : 8'h00; // RL16
            end
            if (tick)
            begin
               first_r <= 1'b1;
               pre_r <= (pre_r == m_r || !pwm8) ? 8'h00 : pre_r + 8'h01;
            end
            if (pwm_step)
            begin
               if (cnt_r == pwm_last)
               begin
                  cnt_r <= `OTM_ZERO16;
                  duty_r <= pwm8 ? {8'h00, reload_r[15:8]} : reload_r; // RL18
                  m_r <= pwm8 ? reload_r[7:0] : 8'h00;
               end
               else
                  cnt_r <= cnt_r + `OTM_ONE16;
            end
         end
      end
      else
      begin
         counting_r <= 1'b0;
         first_r <= 1'b0;
      end
   end

   // Z-phase clear, pending until the next count timing
   always @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         zpend_r <= 1'b0;
         o_zclear <= 1'b0;
      end
      else
      begin
         o_zclear <= 1'b0;
         if (!z_ok)
            zpend_r <= 1'b0;
         else if (zpend_r && i_quad_count_tick)
         begin
            o_zclear <= 1'b1; // RL1 RL6
            zpend_r <= z_edge;
         end
         else if (z_edge)
            zpend_r <= 1'b1;
      end
   end

   // Pulse pin and interrupt request
   always @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         o_pulse_output_pin <= 1'b0;
         o_pulse_output_oe <= 1'b0;
         o_irq_req <= 1'b0;
         irq2_r <= 1'b0;
      end
      else
      begin
         o_pulse_output_pin <= out_nxt & mode_r[`OTM_MODE_POUT];
         o_pulse_output_oe <= mode_r[`OTM_MODE_POUT] & (os_mode | pwm_mode);
         irq2_r <= 1'b0;
         if (md == `OTM_MD_EVENT)
         begin
            o_irq_req <= o_zclear | i_quad_ovf | irq2_r;
            irq2_r <= o_zclear & i_quad_ovf; // RL7
         end
         else if (os_mode)
            o_irq_req <= run_r && counting_r && tick && cnt_r == `OTM_ONE16 &&
                         !(swtrig_r || trig_any); // RL14
         else if (pwm_mode)
            o_irq_req <= o_pulse_output_pin & ~(out_nxt & mode_r[`OTM_MODE_POUT]); // RL22
         else
            o_irq_req <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ### tb/otm_checker.sv
/* Port assertions for the timer channel.
   Assumes it is bound into every otm_timer instance. */
`timescale 1ns/1ps
`default_nettype none
module otm_checker
(
   // Clock, reset and bus
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   // Timer pins
   input wire logic i_quad_count_tick,
   input wire logic o_zclear,
   input wire logic o_pulse_output_pin,
   input wire logic o_pulse_output_oe,
   input wire logic o_irq_req
);
   logic irq_r;
   always @(posedge i_ref_clk)
   begin
      irq_r <= o_irq_req;
   end
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);
   sequence s_req;
      (i_avs_read || i_avs_write) && o_avs_waitrequest;
   endsequence
   sequence s_ack;
      !o_avs_waitrequest ##1 o_avs_waitrequest;
   endsequence
   AST_BUS_ACK: assert property (s_req |=> s_ack)
      else $error("bus request not answered in one cycle");
   AST_BUS_IDLE: assert property (!i_avs_read && !i_avs_write |=> o_avs_waitrequest)
      else $error("waitrequest low without request");
   AST_RD_HOLD: assert property (!i_avs_read && !i_avs_write |=> $stable(o_avs_readdata))
      else $error("read data moved without a read");
   AST_RST_VAL: assert property ($past(i_sys_rst) |-> o_avs_waitrequest
      && o_avs_readdata == 32'h0 && !o_irq_req && !o_pulse_output_pin && !o_zclear)
      else $error("outputs not at reset values");
   AST_ZCLR_TICK: assert property (o_zclear |-> $past(i_quad_count_tick))
      else $error("zero-clear off the count timing");
   AST_ZCLR_PULSE: assert property (o_zclear |=> !o_zclear)
      else $error("zero-clear longer than one cycle");
   AST_ZCLR_IRQ: assert property (o_zclear |-> ##[0:1] o_irq_req)
      else $error("zero-clear without request");
   AST_PIN_OE: assert property (o_pulse_output_pin |-> o_pulse_output_oe)
      else $error("pulse pin high while not driven");
   AST_FALL_IRQ: assert property ($fell(o_pulse_output_pin) |-> ##[0:2] (o_irq_req || irq_r))
      else $error("pulse end without request");
endmodule
bind otm_timer otm_checker chk_u (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
   .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
   .o_avs_waitrequest(o_avs_waitrequest), .i_quad_count_tick(i_quad_count_tick),
   .o_zclear(o_zclear), .o_pulse_output_pin(o_pulse_output_pin),
   .o_pulse_output_oe(o_pulse_output_oe), .o_irq_req(o_irq_req));
`default_nettype wire

// ### tb/otm_partner.sv
/* Far-side model: sub-clock ticks, quadrature counter and Z-phase pin.
   Assumes the bench asks for Z pulses with i_zgo. */
`timescale 1ns/1ps
`default_nettype none
module otm_partner
(
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   // Requests
   input wire logic i_zgo,
   input wire logic i_zclear,
   // Far-side signals
   output logic o_subclk_tick,
   output logic o_qtick,
   output logic o_qovf,
   output logic [15:0] o_qcount,
   output logic o_zphase
);
   logic [2:0] div_r;
   logic [3:0] zw_r;
   assign o_subclk_tick = div_r == 3'h0;
   assign o_qtick = div_r[1:0] == 2'h1;
   assign o_qovf = o_qtick && o_qcount == 16'hFFFF;
   assign o_zphase = zw_r != 4'h0;
   always @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         div_r <= 3'h0;
         zw_r <= 4'h0;
         o_qcount <= 16'hFFF0;
      end
      else
      begin
         div_r <= div_r + 3'h1;
         zw_r <= i_zgo ? 4'hC : zw_r - {3'h0, zw_r != 4'h0};
         if (i_zclear)
            o_qcount <= 16'h0000;
         else if (o_qtick)
            o_qcount <= o_qcount + 16'h0001;
      end
   end
endmodule
`default_nettype wire

// ### tb/otm_timer_tb_top.sv
/* Bench for the timer channel: bus, one-shot, PWM and Z-phase.
   Assumes the partner model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
`include "otm_defs.vh"
module otm_timer_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic rd = 1'b0, wr = 1'b0, tp = 1'b0, po = 1'b0, zgo = 1'b0;
   logic [4:0] adr = 5'h00, co = 5'h00;
   logic [31:0] wd = 32'h0, rdat, v;
   logic st, qt, qo, zp, zc, pin, oe, irq, wt;
   logic [15:0] qc;
   int miscompares = 0, n_compared = 0, irqs = 0, hic = 0, cyc = 0;
   int h0, q0, c0, n, m, i, k;
   always #5 clk = ~clk;
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      hic <= hic + (pin === 1'b1);
      irqs <= irqs + (irq === 1'b1);
   end
   otm_timer #(.CHAN_IDX(3'h3), .QUAD_CHAN(1), .ADDR_W(5)) dut_u (.i_ref_clk(clk),
      .i_sys_rst(rst), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
      .i_avs_writedata(wd), .o_avs_readdata(rdat), .o_avs_waitrequest(wt),
      .i_trigger_input_pin(tp), .i_partner_ovf(po), .i_chan_ovf(co), .i_subclk_tick(st),
      .i_zphase_pin(zp), .i_quad_count_tick(qt), .i_quad_ovf(qo), .i_quad_count(qc),
      .o_zclear(zc), .o_pulse_output_pin(pin), .o_pulse_output_oe(oe), .o_irq_req(irq));
   otm_partner far_u (.i_ref_clk(clk), .i_sys_rst(rst), .i_zgo(zgo), .i_zclear(zc),
      .o_subclk_tick(st), .o_qtick(qt), .o_qovf(qo), .o_qcount(qc), .o_zphase(zp));
   task report_and_stop;
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input string nm, input [31:0] e, input [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         miscompares++;
         $display("BAD %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task bus(input logic w, input [4:0] a, input [31:0] d);
      int j;
      @(posedge clk);
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      @(posedge clk);
      for (j = 0; j < 20 && wt !== 1'b0; j++) @(posedge clk);
      if (j == 20)
      begin
         miscompares++;
         report_and_stop();
      end
      v = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task wpin(input logic l);
      int j;
      for (j = 0; j < 70000 && pin !== l; j++) @(negedge clk);
      if (j == 70000)
      begin
         miscompares++;
         report_and_stop();
      end
   endtask
   task snap;
      h0 = hic;
      q0 = irqs;
      c0 = cyc;
   endtask
   task done;
      repeat (4) @(negedge clk);
      wpin(1'b0);
      repeat (3) @(negedge clk);
   endtask
   task os(input int n0, input [31:0] md);
      bus(1'b1, `OTM_OFS_MODE, md);
      bus(1'b1, `OTM_OFS_COUNT, n0);
      bus(1'b1, `OTM_OFS_CTRL, 32'h1);
      snap();
      bus(1'b1, `OTM_OFS_CTRL, 32'h3);
   endtask
   task rst3;
      if (!rst)
         @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
   endtask
   function automatic int dv(input int cs);
      return (cs == 4) ? 256 : (cs == 3) ? 32 : (cs == 2) ? 8 : cs + 1;
   endfunction
   function automatic logic okw(input int w, input int n0, input int d);
      return n0 == 0 ? w == 0 : (w > (n0 - 1) * d) && (w <= n0 * d + 1);
   endfunction
   initial
   begin
      i = $urandom(32'h7B51);
      rst3();
      bus(1'b1, 5'h14, 32'h1);
      bus(1'b0, 5'h14, 32'h0);
      chk("unmapped", 32'h0, v);
      bus(1'b0, `OTM_OFS_COUNT, 32'h0);
      chk("count read", 32'hFFFF, v);
      for (i = 0; i < 5; i++)
      begin
         n = (i == 0) ? 0 : 1 + $urandom % 4;
         os(n, 32'h8 | (i << 4));
         done();
         chk("os width", 1, okw(hic - h0, n, dv(i)));
         chk("os irq", n > 0, irqs - q0);
      end
      for (i = 0; i < 4; i++)
      begin
         bus(1'b1, `OTM_OFS_MODE, 32'h408 | (i << 7));
         bus(1'b1, `OTM_OFS_COUNT, 32'h4);
         bus(1'b1, `OTM_OFS_CTRL, 32'h1);
         co <= 5'h01;
         @(posedge clk) co <= 5'h00;
         repeat (3) @(negedge clk);
         chk("no start", 0, pin);
         snap();
         @(posedge clk) tp <= (i == 0);
         po <= (i == 1);
         co <= (i == 2) ? 5'h04 : (i == 3) ? 5'h10 : 5'h00;
         @(posedge clk) tp <= 1'b0;
         po <= 1'b0;
         co <= 5'h00;
         done();
         chk("trigger", 1, okw(hic - h0, 4, 1));
      end
      os(12, 32'h8);
      bus(1'b1, `OTM_OFS_CTRL, 32'h3);
      bus(1'b1, `OTM_OFS_COUNT, 32'h2);
      done();
      chk("retrigger", 1, hic - h0 >= 14 && hic - h0 <= 17);
      snap();
      bus(1'b1, `OTM_OFS_CTRL, 32'h3);
      done();
      chk("reload", 1, okw(hic - h0, 2, 1));
      rst3();
      n = 1 + $urandom % 8;
      m = $urandom % 3;
      bus(1'b1, `OTM_OFS_MODE, 32'h28D);
      bus(1'b1, `OTM_OFS_COUNT, (n << 8) | m);
      bus(1'b1, `OTM_OFS_CTRL, 32'h1);
      bus(1'b0, `OTM_OFS_MODE, 32'h0);
      chk("mode", 32'h28D, v);
      chk("oe", 1, oe);
      repeat (20) @(negedge clk);
      chk("pwm waits", 0, pin);
      @(posedge clk) po <= 1'b1;
      @(posedge clk) po <= 1'b0;
      for (i = 0; i < 2; i++)
      begin
         wpin(1'b1);
         snap();
         @(posedge clk) po <= (i == 1);
         @(posedge clk) po <= 1'b0;
         wpin(1'b0);
         wpin(1'b1);
         chk("pwm period", 255 * (m + 1), cyc - c0);
         chk("pwm high", n * (m + 1), hic - h0);
         chk("pwm irq", 1, irqs - q0);
      end
      rst3();
      n = 1 + $urandom % 100;
      bus(1'b1, `OTM_OFS_MODE, 32'h9);
      bus(1'b1, `OTM_OFS_COUNT, n);
      bus(1'b1, `OTM_OFS_CTRL, 32'h1);
      wpin(1'b1);
      snap();
      wpin(1'b0);
      chk("pwm16 high", n, hic - h0);
      for (i = 0; i < 4; i++)
      begin
         rst3();
         bus(1'b1, `OTM_OFS_MODE, (i == 2) ? 32'h1802 : 32'h3802);
         bus(1'b1, `OTM_OFS_COUNT, 32'h0);
         bus(1'b1, `OTM_OFS_ZCTRL, (i == 0) ? 32'h3 : (i == 3) ? 32'h0 : 32'h1);
         chk("oe off", 0, oe);
         @(posedge clk) zgo <= 1'b1;
         @(posedge clk) zgo <= 1'b0;
         for (k = 0; k < 30 && zc !== 1'b1; k++) @(negedge clk);
         chk("zclear", i < 2, k < 30);
         if (k < 30)
         begin
            chk("z edge", i == 0, zp);
            @(negedge clk);
            chk("quad count", 0, qc);
         end
      end
      report_and_stop();
   end
endmodule
`default_nettype wire
